// ==== rtl/css_pkg.sv ====
package css_pkg;
   // Special register indices; the bus byte address is four times the index
   localparam logic [7:0] ADDR_SP = 8'h81;
   localparam logic [7:0] ADDR_PTR_LOW = 8'h82;
   localparam logic [7:0] ADDR_PTR_HIGH = 8'h83;
   localparam logic [7:0] ADDR_AUX_CTRL = 8'hA2;
   localparam logic [7:0] ADDR_PSW = 8'hD0;
   localparam logic [7:0] ADDR_ACC = 8'hE0;
   localparam logic [7:0] ADDR_MULOP = 8'hF0;

   localparam int BUS_ADDR_W = 10;

   localparam logic [7:0] RST_SP = 8'h07;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // Status word bit positions
   localparam int PSW_CARRY = 7;
   localparam int PSW_AUX_CARRY = 6;
   localparam int PSW_USER0 = 5;
   localparam int PSW_BANK_HI = 4;
   localparam int PSW_BANK_LO = 3;
   localparam int PSW_OVERFLOW = 2;
   localparam int PSW_USER1 = 1;
   localparam int PSW_PARITY = 0;

   // Pointer bank control bit positions
   localparam int AUX_FLAG2 = 3;
   localparam int AUX_PTR_SEL = 0;

   localparam int NUM_PTR_SETS = 2;
   localparam int BANK_SHIFT = 3;

   // Arithmetic operation codes from the datapath
   localparam logic [2:0] OP_ADD = 3'h0;
   localparam logic [2:0] OP_ADDC = 3'h1;
   localparam logic [2:0] OP_SUBB = 3'h2;
   localparam logic [2:0] OP_MUL = 3'h3;
   localparam logic [2:0] OP_DIV = 3'h4;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/css_core_regs.sv ====
module css_core_regs (
   input wire logic clk,
   input wire logic rst_n,
   // AXI4-Lite slave
   input wire logic [css_pkg::BUS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [css_pkg::BUS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Execution datapath side
   input wire logic coreWe,
   input wire logic coreRe,
   input wire logic [7:0] coreAddr,
   input wire logic [7:0] coreWdata,
   output logic [7:0] coreRdata,
   input wire logic pushGo,
   input wire logic popGo,
   input wire logic aluGo,
   input wire logic [2:0] aluOp,
   input wire logic [7:0] aluOperand,
   input wire logic carryWe,
   input wire logic carryValue,
   input wire logic pointerWe,
   input wire logic [15:0] pointerWdata,
   input wire logic pointerInc,
   output logic [7:0] stackPointer,
   output logic [7:0] accumulator,
   output logic [7:0] multiplyOperand,
   output logic [15:0] dataPointer,
   output logic [4:0] bankBase,
   output logic parityFlag
);
   logic [7:0] sp;
   logic [7:0] acc;
   logic [7:0] mulOp;
   logic carryFlag;
   logic auxCarryFlag;
   logic userFlagZero;
   logic [1:0] bankSelect;
   logic overflowFlag;
   logic userFlagOne;
   logic generalFlagTwo;
   logic pointerSelect;
   logic [15:0] ptrSet [css_pkg::NUM_PTR_SETS];

   logic awHeld;
   logic wHeld;
   logic [7:0] awIndex;
   logic [7:0] wByte;
   logic wLane;

   wire [7:0] auxByte = {4'h0, generalFlagTwo, 2'h0, pointerSelect};
   wire [7:0] pswByte = {carryFlag, auxCarryFlag, userFlagZero, bankSelect,
                         overflowFlag, userFlagOne, parityFlag};
   // Every register value goes in as an argument, so the continuous reads below follow each change
   wire [55:0] sfrImage = {sp, dataPointer, auxByte, pswByte, acc, mulOp};

   // Register read mux, shared by bus and core
   function automatic logic [8:0] read_sfr(input logic [7:0] idx, input logic [55:0] img);
      logic [8:0] r;
      r = 9'h000;
      unique case (idx)
         css_pkg::ADDR_SP: r = {1'b1, img[55:48]};
         css_pkg::ADDR_PTR_LOW: r = {1'b1, img[39:32]};
         css_pkg::ADDR_PTR_HIGH: r = {1'b1, img[47:40]};
         css_pkg::ADDR_AUX_CTRL: r = {1'b1, img[31:24]};
         css_pkg::ADDR_PSW: r = {1'b1, img[23:16]};
         css_pkg::ADDR_ACC: r = {1'b1, img[15:8]};
         css_pkg::ADDR_MULOP: r = {1'b1, img[7:0]};
         default: r = 9'h000;
      endcase
      return r;
   endfunction

   // AXI write: address and data latched independently; the core port has priority
   wire awTake = s_axi_awvalid & s_axi_awready;
   wire wTake = s_axi_wvalid & s_axi_wready;
   wire busWriteGo = awHeld & wHeld & ~s_axi_bvalid & ~coreWe;
   wire [8:0] busWriteHit = read_sfr(awIndex, sfrImage);
   assign s_axi_awready = ~awHeld;
   assign s_axi_wready = ~wHeld;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awIndex <= 8'h00;
         wByte <= 8'h00;
         wLane <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= css_pkg::RESP_OKAY;
      end else begin
         if (awTake) begin
            awHeld <= 1'b1;
            awIndex <= s_axi_awaddr[css_pkg::BUS_ADDR_W-1:2];
         end
         if (wTake) begin
            wHeld <= 1'b1;
            wByte <= s_axi_wdata[7:0];
            wLane <= s_axi_wstrb[0];
         end
         if (busWriteGo) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= busWriteHit[8] ? css_pkg::RESP_OKAY : css_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI read: one cycle after the address is taken
   wire arTake = s_axi_arvalid & s_axi_arready;
   wire [8:0] busRead = read_sfr(s_axi_araddr[css_pkg::BUS_ADDR_W-1:2], sfrImage);
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= css_pkg::RESP_OKAY;
      end else if (arTake) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, busRead[7:0]};
         s_axi_rresp <= busRead[8] ? css_pkg::RESP_OKAY : css_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Core read port, registered
   wire [8:0] coreRead = read_sfr(coreAddr, sfrImage);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         coreRdata <= 8'h00;
      end else if (coreRe) begin
         coreRdata <= coreRead[7:0];
      end
   end

   // Merged special-register write path
   wire sfrWe = coreWe | (busWriteGo & wLane);
   wire [7:0] sfrAddr = coreWe ? coreAddr : awIndex;
   wire [7:0] sfrData = coreWe ? coreWdata : wByte;
   wire wrSp = sfrWe & (sfrAddr == css_pkg::ADDR_SP);
   wire wrPtrLow = sfrWe & (sfrAddr == css_pkg::ADDR_PTR_LOW);
   wire wrPtrHigh = sfrWe & (sfrAddr == css_pkg::ADDR_PTR_HIGH);
   wire wrAux = sfrWe & (sfrAddr == css_pkg::ADDR_AUX_CTRL);
   wire wrPsw = sfrWe & (sfrAddr == css_pkg::ADDR_PSW);
   wire wrAcc = sfrWe & (sfrAddr == css_pkg::ADDR_ACC);
   wire wrMulOp = sfrWe & (sfrAddr == css_pkg::ADDR_MULOP);

   // Arithmetic flag generation
   wire isAdd = (aluOp == css_pkg::OP_ADD) | (aluOp == css_pkg::OP_ADDC);
   wire isSub = aluOp == css_pkg::OP_SUBB;
   wire isMul = aluOp == css_pkg::OP_MUL;
   wire isDiv = aluOp == css_pkg::OP_DIV;
   wire carryIn = (aluOp == css_pkg::OP_ADD) ? 1'b0 : carryFlag;
   wire [8:0] sumFull = {1'b0, acc} + {1'b0, aluOperand} + {8'h00, carryIn};
   wire [4:0] sumNibble = {1'b0, acc[3:0]} + {1'b0, aluOperand[3:0]} + {4'h0, carryIn};
   wire [8:0] diffFull = {1'b0, acc} - {1'b0, aluOperand} - {8'h00, carryIn};
   wire [4:0] diffNibble = {1'b0, acc[3:0]} - {1'b0, aluOperand[3:0]} - {4'h0, carryIn};
   wire addOverflow = (acc[7] == aluOperand[7]) & (sumFull[7] != acc[7]);
   wire subOverflow = (acc[7] != aluOperand[7]) & (diffFull[7] != acc[7]);
   wire [15:0] product = {8'h00, acc} * {8'h00, mulOp};
   wire divZero = mulOp == 8'h00;
   // Quotient and remainder hold their old value when the divisor is zero
   wire [7:0] quotient = divZero ? acc : acc / mulOp;
   wire [7:0] remainder = divZero ? mulOp : acc % mulOp;

   logic [7:0] next_acc;
   logic [7:0] next_mulOp;
   logic next_carry;
   logic next_auxCarry;
   logic next_overflow;

   always_comb begin
      next_acc = acc;
      next_mulOp = mulOp;
      next_carry = carryFlag;
      next_auxCarry = auxCarryFlag;
      next_overflow = overflowFlag;
      if (wrAcc) next_acc = sfrData;
      if (wrMulOp) next_mulOp = sfrData;
      if (wrPsw) begin
         next_carry = sfrData[css_pkg::PSW_CARRY];
         next_auxCarry = sfrData[css_pkg::PSW_AUX_CARRY];
         next_overflow = sfrData[css_pkg::PSW_OVERFLOW];
      end
      if (carryWe) next_carry = carryValue;
      // Hardware results win over a software write in the same cycle
      if (aluGo) begin
         if (isAdd) begin
            next_acc = sumFull[7:0];
            next_carry = sumFull[8];
            next_auxCarry = sumNibble[4];
            next_overflow = addOverflow;
         end else if (isSub) begin
            next_acc = diffFull[7:0];
            next_carry = diffFull[8];
            next_auxCarry = diffNibble[4];
            next_overflow = subOverflow;
         end else if (isMul) begin
            next_acc = product[7:0];
            next_mulOp = product[15:8];
            next_carry = 1'b0;
            next_auxCarry = 1'b0;
            next_overflow = product[15:8] != 8'h00;
         end else if (isDiv) begin
            next_acc = quotient;
            next_mulOp = remainder;
            next_carry = 1'b0;
            next_auxCarry = 1'b0;
            next_overflow = divZero;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc <= css_pkg::RST_ZERO;
         mulOp <= css_pkg::RST_ZERO;
         carryFlag <= 1'b0;
         auxCarryFlag <= 1'b0;
         overflowFlag <= 1'b0;
      end else begin
         acc <= next_acc;
         mulOp <= next_mulOp;
         carryFlag <= next_carry;
         auxCarryFlag <= next_auxCarry;
         overflowFlag <= next_overflow;
      end
   end

   // Remaining status bits and the pointer bank control
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         userFlagZero <= 1'b0;
         userFlagOne <= 1'b0;
         bankSelect <= 2'b00;
         generalFlagTwo <= 1'b0;
         pointerSelect <= 1'b0;
      end else begin
         if (wrPsw) begin
            userFlagZero <= sfrData[css_pkg::PSW_USER0];
            userFlagOne <= sfrData[css_pkg::PSW_USER1];
            bankSelect <= {sfrData[css_pkg::PSW_BANK_HI], sfrData[css_pkg::PSW_BANK_LO]};
         end
         if (wrAux) begin
            generalFlagTwo <= sfrData[css_pkg::AUX_FLAG2];
            pointerSelect <= sfrData[css_pkg::AUX_PTR_SEL];
         end
      end
   end

   // Stack pointer wraps at 8 bits so the whole 256-byte RAM is reachable
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sp <= css_pkg::RST_SP;
      end else if (pushGo) begin
         sp <= sp + 8'h01;
      end else if (popGo) begin
         sp <= sp - 8'h01;
      end else if (wrSp) begin
         sp <= sfrData;
      end
   end

   // Two pointer sets; only the selected one sees any access
   genvar g;
   generate
      for (g = 0; g < css_pkg::NUM_PTR_SETS; g++) begin : gPtr
         wire mine = pointerSelect == 1'(g);
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               ptrSet[g] <= 16'h0000;
            end else if (mine) begin
               if (pointerWe) begin
                  ptrSet[g] <= pointerWdata;
               end else if (pointerInc) begin
                  ptrSet[g] <= ptrSet[g] + 16'h0001;
               end else begin
                  if (wrPtrLow) ptrSet[g][7:0] <= sfrData;
                  if (wrPtrHigh) ptrSet[g][15:8] <= sfrData;
               end
            end
         end
      end
   endgenerate

   assign dataPointer = ptrSet[pointerSelect];
   assign parityFlag = ^acc;
   assign bankBase = {bankSelect, 3'b000};
   assign stackPointer = sp;
   assign accumulator = acc;
   assign multiplyOperand = mulOp;

   // Checks
   sp_reset_a: assert property (@(posedge clk) $rose(rst_n) |-> sp == css_pkg::RST_SP)
      else $error("stack pointer not 07H after reset");
   sp_push_a: assert property (@(posedge clk) disable iff (!rst_n)
      pushGo |=> sp == $past(sp) + 8'h01)
      else $error("push did not increment stack pointer");
   parity_a: assert property (@(posedge clk) disable iff (!rst_n)
      arTake && s_axi_araddr[css_pkg::BUS_ADDR_W-1:2] == css_pkg::ADDR_PSW
         |=> s_axi_rdata[css_pkg::PSW_PARITY] == ^$past(acc))
      else $error("parity bit read back disagrees with accumulator");
   carry_add_a: assert property (@(posedge clk) disable iff (!rst_n)
      aluGo && aluOp == css_pkg::OP_ADD |=> carryFlag == (({1'b0, $past(acc)} + {1'b0, $past(aluOperand)}) > 9'h0FF))
      else $error("carry wrong after add");
   ov_mul_a: assert property (@(posedge clk) disable iff (!rst_n)
      aluGo && aluOp == css_pkg::OP_MUL |=> overflowFlag == ((16'($past(acc)) * 16'($past(mulOp))) > 16'h00FF)
         && !carryFlag)
      else $error("multiply overflow flag wrong");
   ov_div_a: assert property (@(posedge clk) disable iff (!rst_n)
      aluGo && aluOp == css_pkg::OP_DIV && mulOp == 8'h00 |=> overflowFlag && acc == $past(acc))
      else $error("divide by zero did not set overflow");
   ptr_select_a: assert property (@(posedge clk) disable iff (!rst_n)
      pointerWe && pointerSelect |=> ptrSet[1] == $past(pointerWdata) && $stable(ptrSet[0]))
      else $error("pointer write reached the wrong set");
   aux_unused_a: assert property (@(posedge clk) disable iff (!rst_n)
      arTake && s_axi_araddr[css_pkg::BUS_ADDR_W-1:2] == css_pkg::ADDR_AUX_CTRL
         |=> (s_axi_rdata[7:0] & 8'hF6) == 8'h00)
      else $error("aux control shows unimplemented bits");
   aux_store_a: assert property (@(posedge clk) disable iff (!rst_n)
      wrAux |=> generalFlagTwo == $past(sfrData[css_pkg::AUX_FLAG2])
         && pointerSelect == $past(sfrData[css_pkg::AUX_PTR_SEL]))
      else $error("aux control bits not stored");
   user_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
      wrPsw |=> userFlagZero == $past(sfrData[css_pkg::PSW_USER0])
         && userFlagOne == $past(sfrData[css_pkg::PSW_USER1]))
      else $error("user flags not stored");
   ptr_reset_a: assert property (@(posedge clk)
      $rose(rst_n) |-> !pointerSelect && dataPointer == ptrSet[0])
      else $error("primary pointer not selected after reset");
   bank_map_a: assert property (@(posedge clk) disable iff (!rst_n)
      wrPsw |=> bankBase == {$past(sfrData[4:3]), 3'b000})
      else $error("bank base does not follow select bits");
endmodule

// ==== verif/css_datapath_model.sv ====
module css_datapath_model (
   input wire logic clk,
   output logic coreWe,
   output logic coreRe,
   output logic [7:0] coreAddr,
   output logic [7:0] coreWdata,
   input wire logic [7:0] coreRdata,
   output logic pushGo,
   output logic popGo,
   output logic aluGo,
   output logic [2:0] aluOp,
   output logic [7:0] aluOperand,
   output logic carryWe,
   output logic carryValue,
   output logic pointerWe,
   output logic [15:0] pointerWdata,
   output logic pointerInc
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {coreWe, coreRe, pushGo, popGo, aluGo, carryWe, pointerWe, pointerInc} = 8'h00;
      {coreAddr, coreWdata, aluOp, aluOperand, carryValue, pointerWdata} = 44'h0;
   end

   // Operands are inverted once the strobe drops, so a core that samples late sees garbage
   task automatic hold();
      @(posedge clk);
      {coreWe, coreRe, pushGo, popGo, aluGo, carryWe, pointerWe, pointerInc} <= 8'h00;
      {coreAddr, coreWdata, aluOp, aluOperand, carryValue, pointerWdata} <=
         ~{coreAddr, coreWdata, aluOp, aluOperand, carryValue, pointerWdata};
      #1;
   endtask

   task automatic push();
      @(posedge clk);
      pushGo <= 1'b1;
      hold();
   endtask

   task automatic pop();
      @(posedge clk);
      popGo <= 1'b1;
      hold();
   endtask

   task automatic alu(input logic [2:0] op, input logic [7:0] opnd);
      @(posedge clk);
      aluGo <= 1'b1;
      aluOp <= op;
      aluOperand <= opnd;
      hold();
   endtask

   task automatic setCarry(input logic v);
      @(posedge clk);
      carryWe <= 1'b1;
      carryValue <= v;
      hold();
   endtask

   task automatic loadPointer(input logic [15:0] v);
      @(posedge clk);
      pointerWe <= 1'b1;
      pointerWdata <= v;
      hold();
   endtask

   task automatic incPointer();
      @(posedge clk);
      pointerInc <= 1'b1;
      hold();
   endtask

   task automatic coreAccess(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      coreWe <= we;
      coreRe <= !we;
      coreAddr <= a;
      coreWdata <= d;
      hold();
      q = coreRdata;
   endtask
endmodule

// ==== verif/testbench.sv ====
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [css_pkg::BUS_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, parityFlag;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic coreWe, coreRe, pushGo, popGo, aluGo, carryWe, carryValue, pointerWe, pointerInc;
   logic [7:0] coreAddr, coreWdata, coreRdata, aluOperand, stackPointer, accumulator, multiplyOperand, q;
   logic [2:0] aluOp;
   logic [15:0] pointerWdata, dataPointer;
   logic [4:0] bankBase;
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;

   css_core_regs u_css_core_regs (
      .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .coreWe, .coreRe, .coreAddr, .coreWdata, .coreRdata, .pushGo, .popGo, .aluGo, .aluOp, .aluOperand,
      .carryWe, .carryValue, .pointerWe, .pointerWdata, .pointerInc, .stackPointer, .accumulator,
      .multiplyOperand, .dataPointer, .bankBase, .parityFlag
   );

   css_datapath_model u_css_datapath_model (
      .clk, .coreWe, .coreRe, .coreAddr, .coreWdata, .coreRdata, .pushGo, .popGo, .aluGo, .aluOp,
      .aluOperand, .carryWe, .carryValue, .pointerWe, .pointerWdata, .pointerInc
   );

   always #5 clk = ~clk;

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Run is well under 3000 cycles; the ceiling only catches a hung handshake
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] val, input logic strb, input logic [1:0] eResp);
      logic awDone;
      logic wDone;
      logic [1:0] r;
      awDone = 1'b0;
      wDone = 1'b0;
      r = 2'bxx;
      @(posedge clk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h000000, val};
      s_axi_wstrb <= {3'h0, strb};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      // Ends when s_axi_bvalid is seen; if it never comes, the bench timeout ends the wait
      while (1'b1) begin
         @(posedge clk);
         if (!awDone && s_axi_awready) begin
            awDone = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wDone && s_axi_wready) begin
            wDone = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
      #1;
      check(r, eResp, "write response");
   endtask

   task automatic rdRaw(input logic [7:0] idx);
      rd = 32'hXXXXXXXX;
      rsp = 2'bxx;
      @(posedge clk);
      s_axi_araddr <= {idx, 2'b00};
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      while (1'b1) begin
         @(posedge clk);
         if (s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid) begin
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
      #1;
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      rdRaw(idx);
      check({rsp, rd}, {css_pkg::RESP_OKAY, 24'h000000, exp}, "register read");
   endtask

   task automatic aluCase(input logic [7:0] a, b, p, input logic [2:0] op, input logic [7:0] opnd, eA, eB,
                          input logic [2:0] eF);
      wr(css_pkg::ADDR_ACC, a, 1'b1, css_pkg::RESP_OKAY);
      wr(css_pkg::ADDR_MULOP, b, 1'b1, css_pkg::RESP_OKAY);
      wr(css_pkg::ADDR_PSW, p, 1'b1, css_pkg::RESP_OKAY);
      u_css_datapath_model.alu(op, opnd);
      check(accumulator, eA, "alu result");
      check(multiplyOperand, eB, "operand register");
      check(parityFlag, ^eA, "parity output");
      rdRaw(css_pkg::ADDR_PSW);
      check({rd[7:6], rd[2], rd[0]}, {eF, ^eA}, "status flags");
   endtask

   initial begin
      logic [7:0] idxTab [7];
      idxTab = '{css_pkg::ADDR_SP, css_pkg::ADDR_PTR_LOW, css_pkg::ADDR_PTR_HIGH, css_pkg::ADDR_AUX_CTRL,
                 css_pkg::ADDR_PSW, css_pkg::ADDR_ACC, css_pkg::ADDR_MULOP};
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rdc(idxTab[i], (i == 0) ? 8'h07 : 8'h00);
      end
      u_css_datapath_model.push();
      check(stackPointer, 8'h08, "first push");
      u_css_datapath_model.pop();
      check(stackPointer, 8'h07, "pop");
      wr(css_pkg::ADDR_SP, 8'hFF, 1'b1, css_pkg::RESP_OKAY);
      u_css_datapath_model.push();
      check(stackPointer, 8'h00, "push wraps");
      for (int i = 0; i < 4; i++) begin
         wr(css_pkg::ADDR_PSW, {2'b00, 1'b1, i[1:0], 3'b011}, 1'b1, css_pkg::RESP_OKAY);
         check(bankBase, {i[1:0], 3'b000}, "bank base");
         rdc(css_pkg::ADDR_PSW, {2'b00, 1'b1, i[1:0], 3'b010});
      end
      wr(css_pkg::ADDR_PSW, 8'h00, 1'b1, css_pkg::RESP_OKAY);
      u_css_datapath_model.setCarry(1'b1);
      rdc(css_pkg::ADDR_PSW, 8'h80);
      aluCase(8'h7F, 8'h00, 8'h00, css_pkg::OP_ADD, 8'h01, 8'h80, 8'h00, 3'b011);
      aluCase(8'h80, 8'h00, 8'h00, css_pkg::OP_ADD, 8'h80, 8'h00, 8'h00, 3'b101);
      aluCase(8'h01, 8'h00, 8'hC4, css_pkg::OP_ADD, 8'h01, 8'h02, 8'h00, 3'b000);
      aluCase(8'h0E, 8'h00, 8'h80, css_pkg::OP_ADDC, 8'h01, 8'h10, 8'h00, 3'b010);
      aluCase(8'h00, 8'h00, 8'h00, css_pkg::OP_SUBB, 8'h01, 8'hFF, 8'h00, 3'b110);
      aluCase(8'h80, 8'h00, 8'h80, css_pkg::OP_SUBB, 8'h01, 8'h7E, 8'h00, 3'b011);
      aluCase(8'h10, 8'h10, 8'hC0, css_pkg::OP_MUL, 8'h00, 8'h00, 8'h01, 3'b001);
      aluCase(8'h0F, 8'h02, 8'h04, css_pkg::OP_MUL, 8'h00, 8'h1E, 8'h00, 3'b000);
      aluCase(8'h10, 8'h03, 8'hC4, css_pkg::OP_DIV, 8'h00, 8'h05, 8'h01, 3'b000);
      aluCase(8'h22, 8'h00, 8'h00, css_pkg::OP_DIV, 8'h00, 8'h22, 8'h00, 3'b001);
      wr(css_pkg::ADDR_ACC, 8'h77, 1'b0, css_pkg::RESP_OKAY);
      check(accumulator, 8'h22, "masked write dropped");
      wr(8'h80, 8'h11, 1'b1, css_pkg::RESP_SLVERR);
      rdRaw(8'h80);
      check(rsp, css_pkg::RESP_SLVERR, "unmapped read");
      u_css_datapath_model.coreAccess(1'b1, css_pkg::ADDR_MULOP, 8'h5A, q);
      u_css_datapath_model.coreAccess(1'b0, css_pkg::ADDR_MULOP, 8'h00, q);
      check(q, 8'h5A, "core scratch access");
      wr(css_pkg::ADDR_PTR_LOW, 8'h34, 1'b1, css_pkg::RESP_OKAY);
      wr(css_pkg::ADDR_PTR_HIGH, 8'h12, 1'b1, css_pkg::RESP_OKAY);
      check(dataPointer, 16'h1234, "pointer bytes");
      u_css_datapath_model.incPointer();
      check(dataPointer, 16'h1235, "pointer increment");
      wr(css_pkg::ADDR_AUX_CTRL, 8'hFF, 1'b1, css_pkg::RESP_OKAY);
      rdc(css_pkg::ADDR_AUX_CTRL, 8'h09);
      check(dataPointer, 16'h0000, "second pointer set");
      u_css_datapath_model.loadPointer(16'hABCD);
      rdc(css_pkg::ADDR_PTR_LOW, 8'hCD);
      rdc(css_pkg::ADDR_PTR_HIGH, 8'hAB);
      wr(css_pkg::ADDR_AUX_CTRL, 8'h0A, 1'b1, css_pkg::RESP_OKAY);
      rdc(css_pkg::ADDR_AUX_CTRL, 8'h08);
      check(dataPointer, 16'h1235, "first pointer set kept");
      end_sim();
   end
endmodule
